// file: rtl/pgs_gob_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pgs_gob_if;
	logic step;
	logic vco_en;

	modport ctl (output step, input vco_en);
	modport gob (input step, output vco_en);
endinterface
`default_nettype wire

// file: rtl/pgs_gobbler.sv
`timescale 1ns/10ps
`default_nettype none
module pgs_gobbler
	import pgs_pkg::*;
(
	input wire logic clk_sys_in, // vco rate clock
	input wire logic nrst_in, // async reset, active low
	pgs_gob_if.gob gob // step request in, gated enable out
);
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic swallow_r;
	wire step_rise;

	// ****************************
	// step synchroniser and edge
	// ****************************
	assign step_rise = sync2_r & ~sync3_r;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			swallow_r <= 1'b0;
		end else begin
			sync1_r <= gob.step;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			swallow_r <= step_rise;
		end
	end

	// one vco pulse held back from the post divider
	assign gob.vco_en = ~swallow_r;
endmodule // pgs_gobbler
`default_nettype wire

// file: rtl/pgs_pkg.sv
package pgs_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] REG_XTAL = 3'h1;
	localparam logic [ADDR_W-1:0] REG_OSC = 3'h2;
	localparam logic [ADDR_W-1:0] REG_PDIV = 3'h3;
	localparam logic [ADDR_W-1:0] REG_FDIV = 3'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 3'h5;

	// control register fields
	localparam int CTRL_GOBBLE = 0;
	localparam int CTRL_FBK_SRC = 1;
	localparam int CTRL_STAT_LO = 2;
	localparam int CTRL_STAT_HI = 3;
	localparam int CTRL_SE_EN = 4;

	// crystal register fields
	localparam int XTAL_COARSE_LSB = 0;
	localparam int XTAL_COARSE_W = 4;
	localparam int XTAL_PUMP_OFF = 4;
	localparam int XTAL_FINE_EN = 5;

	localparam int OSC_CTL_W = 3;
	localparam logic [OSC_CTL_W-1:0] OSC_SHUTDOWN_CODE = 3'h1;

	// status register fields
	localparam int STS_LOCK = 0;
	localparam int STS_RANGE = 1;
	localparam int STS_PHASE = 2;

	// reset values
	localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
	localparam logic [DATA_W-1:0] XTAL_RST = 8'h00;
	localparam logic [DATA_W-1:0] OSC_RST = 8'h00;
	localparam logic [DATA_W-1:0] PDIV_RST = 8'h02;
	localparam logic [DATA_W-1:0] FDIV_RST = 8'h04;

	localparam logic [DATA_W-1:0] ONE = 8'h01;

	typedef enum logic [1:0] {
		STAT_LOCK = 2'h0,
		STAT_RANGE = 2'h1,
		STAT_PHASE = 2'h2,
		STAT_FBK_MON = 2'h3
	} pgs_stat_t;
endpackage

// file: rtl/pgs_top.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pgs_top
	import pgs_pkg::*;
(
	input wire logic clk_sys_in, // vco rate clock
	input wire logic nrst_in, // async reset, active low
	input wire logic [ADDR_W-1:0] addr_in, // register address
	input wire logic [DATA_W-1:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [DATA_W-1:0] rdata_out, // read data, cycle after rd
	input wire logic xtal_locked_in, // crystal loop lock detector
	input wire logic xtal_range_high_in, // crystal loop above range
	input wire logic ext_src_lost_in, // external reference missing
	output logic xtal_pump_off_out, // crystal pump disable
	output logic fine_tune_en_out, // tune voltage pin enable
	output logic [XTAL_COARSE_W-1:0] coarse_load_code_out, // load cap code
	output logic osc_shutdown_out, // oscillator stop
	output logic post_clk_out, // post divider output clock
	output logic status_pin_out, // status pin level
	output logic status_pin_oe_n_out, // status pin drive, low drives
	output logic diff_out_pair_p_out, // output clock plus
	output logic diff_out_pair_n_out, // output clock minus
	output logic diff_out_pair_p_oe_n_out, // plus leg drive, low drives
	output logic diff_out_pair_n_oe_n_out // minus leg drive, low drives
);
	// ****************************
	// registers
	// ****************************
	logic [DATA_W-1:0] ctrl_r;
	logic [DATA_W-1:0] xtal_r;
	logic [DATA_W-1:0] osc_r;
	logic [DATA_W-1:0] pdiv_r;
	logic [DATA_W-1:0] fdiv_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	wire wr_ctrl;
	wire wr_xtal;
	wire wr_osc;
	wire wr_pdiv;
	wire wr_fdiv;

	assign wr_ctrl = wr_in && (addr_in == REG_CTRL);
	assign wr_xtal = wr_in && (addr_in == REG_XTAL);
	assign wr_osc = wr_in && (addr_in == REG_OSC);
	assign wr_pdiv = wr_in && (addr_in == REG_PDIV);
	assign wr_fdiv = wr_in && (addr_in == REG_FDIV);

	// writes land on the strobe edge itself
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_r <= CTRL_RST;
			xtal_r <= XTAL_RST;
			osc_r <= OSC_RST;
			pdiv_r <= PDIV_RST;
			fdiv_r <= FDIV_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= wdata_in;
			end
			if (wr_xtal) begin
				xtal_r <= wdata_in;
			end
			if (wr_osc) begin
				osc_r <= wdata_in;
			end
			if (wr_pdiv) begin
				pdiv_r <= wdata_in;
			end
			if (wr_fdiv) begin
				fdiv_r <= wdata_in;
			end
		end
	end

	// ****************************
	// field decode
	// ****************************
	wire fbk_src_sel;
	wire single_ended_out_en;
	pgs_stat_t status_sel;

	assign fbk_src_sel = ctrl_r[CTRL_FBK_SRC];
	assign single_ended_out_en = ctrl_r[CTRL_SE_EN];
	assign status_sel = pgs_stat_t'(ctrl_r[CTRL_STAT_HI:CTRL_STAT_LO]);

	// ****************************
	// gobbler
	// ****************************
	pgs_gob_if gob_if ();

	assign gob_if.step = ctrl_r[CTRL_GOBBLE];

	pgs_gobbler u_gobbler (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.gob(gob_if.gob)
	);

	// ****************************
	// post divider
	// ****************************
	logic [DATA_W-1:0] pcnt_r;
	logic post_clk_r;
	wire pcnt_wrap;
	wire post_rise;
	wire [DATA_W-1:0] phalf;
	wire [DATA_W-1:0] pcnt_nxt;
	wire post_clk_nxt;
	wire pdiv_unit;

	// moduli zero and one both mean divide by one
	assign pdiv_unit = (pdiv_r <= ONE);
	assign pcnt_wrap = pdiv_unit || (pcnt_r >= pdiv_r - ONE);
	assign phalf = pdiv_r >> 1;
	assign pcnt_nxt = pcnt_wrap ? '0 : pcnt_r + ONE;
	assign post_clk_nxt = pcnt_wrap || (pcnt_r + ONE < phalf);
	// counter only advances on pulses the gobbler lets through
	assign post_rise = gob_if.vco_en && pcnt_wrap;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pcnt_r <= '0;
			post_clk_r <= 1'b0;
		end else if (gob_if.vco_en) begin
			pcnt_r <= pcnt_nxt;
			post_clk_r <= post_clk_nxt;
		end
	end

	// ****************************
	// feedback divider
	// ****************************
	logic [DATA_W-1:0] fcnt_r;
	logic fbk_clk_r;
	logic fbk_clk_d_r;
	wire fbk_tick;
	wire fcnt_wrap;
	wire [DATA_W-1:0] fhalf;
	wire [DATA_W-1:0] fcnt_nxt;
	wire fbk_clk_nxt;
	wire fdiv_unit;

	// source is every vco cycle or each post divider period
	// a source switch keeps the count, so the first period may be odd
	assign fbk_tick = fbk_src_sel ? post_rise : 1'b1;
	assign fdiv_unit = (fdiv_r <= ONE);
	assign fcnt_wrap = fdiv_unit || (fcnt_r >= fdiv_r - ONE);
	assign fhalf = fdiv_r >> 1;
	assign fcnt_nxt = fcnt_wrap ? '0 : fcnt_r + ONE;
	assign fbk_clk_nxt = fcnt_wrap || (fcnt_r + ONE < fhalf);

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fcnt_r <= '0;
			fbk_clk_r <= 1'b0;
		end else if (fbk_tick) begin
			fcnt_r <= fcnt_nxt;
			fbk_clk_r <= fbk_clk_nxt;
		end
	end

	// ****************************
	// phase sampling
	// ****************************
	logic phase_flag_r;
	wire fbk_edge;

	assign fbk_edge = fbk_clk_r & ~fbk_clk_d_r;

	// each feedback rising edge samples the output clock
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fbk_clk_d_r <= 1'b0;
			phase_flag_r <= 1'b0;
		end else begin
			fbk_clk_d_r <= fbk_clk_r;
			if (fbk_edge) begin
				phase_flag_r <= post_clk_r;
			end
		end
	end

	// ****************************
	// crystal loop status
	// ****************************
	logic lock_d_r;
	logic range_dir_r;
	wire lock_flag;
	wire lock_lost;

	assign lock_flag = xtal_locked_in & ~ext_src_lost_in;
	assign lock_lost = lock_d_r & ~lock_flag;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lock_d_r <= 1'b0;
			range_dir_r <= 1'b0;
		end else begin
			lock_d_r <= lock_flag;
			if (lock_lost) begin
				range_dir_r <= xtal_range_high_in;
			end
		end
	end

	// ****************************
	// status selection
	// ****************************
	logic status_r;
	logic status_nxt;
	wire flag_mode;

	always_comb begin
		status_nxt = 1'b0;
		unique case (status_sel)
			STAT_LOCK: status_nxt = lock_flag;
			STAT_RANGE: status_nxt = range_dir_r;
			STAT_PHASE: status_nxt = phase_flag_r;
			STAT_FBK_MON: status_nxt = fbk_clk_r;
		endcase
	end

	assign flag_mode = (status_sel != STAT_FBK_MON);

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
		end
	end

	// pin released entirely unless single-ended drive is on
	assign status_pin_out = single_ended_out_en & status_r;
	assign status_pin_oe_n_out = ~single_ended_out_en;

	// ****************************
	// read path
	// ****************************
	logic [DATA_W-1:0] ctrl_rb;
	logic [DATA_W-1:0] status_rb;

	always_comb begin
		ctrl_rb = ctrl_r;
		if (flag_mode) begin
			ctrl_rb[CTRL_STAT_HI] = status_nxt;
		end
	end

	always_comb begin
		status_rb = '0;
		status_rb[STS_LOCK] = lock_flag;
		status_rb[STS_RANGE] = range_dir_r;
		status_rb[STS_PHASE] = phase_flag_r;
	end

	always_comb begin
		rdata_nxt = '0;
		if (rd_in) begin
			unique case (addr_in)
				REG_CTRL: rdata_nxt = ctrl_rb;
				REG_XTAL: rdata_nxt = xtal_r;
				REG_OSC: rdata_nxt = osc_r;
				REG_PDIV: rdata_nxt = pdiv_r;
				REG_FDIV: rdata_nxt = fdiv_r;
				REG_STATUS: rdata_nxt = status_rb;
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;

	// ****************************
	// crystal oscillator controls
	// ****************************
	assign xtal_pump_off_out = xtal_r[XTAL_PUMP_OFF];
	assign fine_tune_en_out = xtal_r[XTAL_FINE_EN];
	assign coarse_load_code_out = xtal_r[XTAL_COARSE_LSB +: XTAL_COARSE_W];
	assign osc_shutdown_out = (osc_r[OSC_CTL_W-1:0] == OSC_SHUTDOWN_CODE);

	// ****************************
	// output stage
	// ****************************
	// pseudo-ECL legs only sink: driven when low, released when high
	assign post_clk_out = post_clk_r;
	assign diff_out_pair_p_out = post_clk_r;
	assign diff_out_pair_n_out = ~post_clk_r;
	assign diff_out_pair_p_oe_n_out = single_ended_out_en ? 1'b0 : post_clk_r;
	assign diff_out_pair_n_oe_n_out = single_ended_out_en ? 1'b0 : ~post_clk_r;
endmodule // pgs_top
`default_nettype wire

// file: testbench/pgs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pgs_assertions
	import pgs_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	input wire logic xtal_locked_in,
	input wire logic ext_src_lost_in,
	input wire logic xtal_pump_off_out,
	input wire logic fine_tune_en_out,
	input wire logic [XTAL_COARSE_W-1:0] coarse_load_code_out,
	input wire logic osc_shutdown_out,
	input wire logic status_pin_out,
	input wire logic status_pin_oe_n_out,
	input wire logic diff_out_pair_p_out,
	input wire logic diff_out_pair_n_out,
	input wire logic diff_out_pair_p_oe_n_out,
	input wire logic diff_out_pair_n_oe_n_out
);
	logic [DATA_W-1:0] ctl_r;
	wire logic wr_ctl = wr_in && addr_in == REG_CTRL;
	wire logic [1:0] sel = ctl_r[CTRL_STAT_HI:CTRL_STAT_LO];
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctl_r <= CTRL_RST;
		end else if (wr_ctl) begin
			ctl_r <= wdata_in;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	property p_pin_off;
		status_pin_oe_n_out |-> !status_pin_out;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("undriven status pin high");
	property p_oe_wr;
		wr_ctl |=> status_pin_oe_n_out == !$past(wdata_in[CTRL_SE_EN]);
	endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("status drive not set by write");
	property p_xtal_wr;
		wr_in && addr_in == REG_XTAL |=>
			{fine_tune_en_out, xtal_pump_off_out, coarse_load_code_out} == $past(wdata_in[5:0]);
	endproperty
	a_xtal_wr: assert property (p_xtal_wr) else $error("crystal controls wrong");
	property p_osc_wr;
		wr_in && addr_in == REG_OSC |=>
			osc_shutdown_out == ($past(wdata_in[2:0]) == OSC_SHUTDOWN_CODE);
	endproperty
	a_osc_wr: assert property (p_osc_wr) else $error("oscillator stop wrong");
	property p_rd_idle;
		!rd_in |=> rdata_out == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_diff_inv;
		diff_out_pair_n_out == !diff_out_pair_p_out;
	endproperty
	a_diff_inv: assert property (p_diff_inv) else $error("output legs not inverse");
	property p_pecl;
		status_pin_oe_n_out |-> diff_out_pair_p_oe_n_out == diff_out_pair_p_out
			&& diff_out_pair_n_oe_n_out == diff_out_pair_n_out;
	endproperty
	a_pecl: assert property (p_pecl) else $error("pseudo-ECL leg sources current");
	property p_cmos;
		!status_pin_oe_n_out |-> !diff_out_pair_p_oe_n_out && !diff_out_pair_n_oe_n_out;
	endproperty
	a_cmos: assert property (p_cmos) else $error("single-ended leg not driven");
	property p_lock;
		!status_pin_oe_n_out && sel == STAT_LOCK && $past(sel) == STAT_LOCK
			|-> status_pin_out == $past(xtal_locked_in && !ext_src_lost_in);
	endproperty
	a_lock: assert property (p_lock) else $error("lock status pin wrong");
	c_gob: cover property (wr_ctl && wdata_in[CTRL_GOBBLE]);
	c_rng: cover property (!status_pin_oe_n_out && status_pin_out && sel == STAT_RANGE);
	c_mon: cover property (sel == STAT_FBK_MON && $rose(status_pin_out));
endmodule // pgs_assertions
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pgs_pkg::*;
	logic clk_sys_in = 1'h0, nrst_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
	logic [ADDR_W-1:0] addr_in = 3'h0;
	logic [DATA_W-1:0] wdata_in = 8'h00, rdata_out;
	logic xtal_locked_in = 1'h0, xtal_range_high_in = 1'h0, ext_src_lost_in = 1'h0;
	logic xtal_pump_off_out, fine_tune_en_out, osc_shutdown_out, post_clk_out;
	logic [XTAL_COARSE_W-1:0] coarse_load_code_out;
	logic status_pin_out, status_pin_oe_n_out, diff_out_pair_p_out, diff_out_pair_n_out;
	logic diff_out_pair_p_oe_n_out, diff_out_pair_n_oe_n_out;
	int err_total = 0, num_checks = 0, cyc = 0;
	logic [31:0] seed = 32'hCC631C27;
	logic [7:0] rst_v [8] = '{CTRL_RST, XTAL_RST, OSC_RST, PDIV_RST, FDIV_RST, 8'h00, 8'h00, 8'h00};
	logic [2:0] lk_t [4] = '{3'h5, 3'h0, 3'h6, 3'h5};
	logic [2:0] rg_t [7] = '{3'h3, 3'h1, 3'h5, 3'h0, 3'h2, 3'h6, 3'h3};
	wire logic [7:0] xtal_obs = {2'h0, fine_tune_en_out, xtal_pump_off_out, coarse_load_code_out};
	pgs_top pgs_top_i (.*);
	always #25 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) cyc++;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		wr_in <= 1'h1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'h0;
		@(posedge clk_sys_in);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		rd_in <= 1'h1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'h0;
		#1 d = rdata_out;
		@(posedge clk_sys_in);
	endtask
	// drive lock inputs, then check pin and live readback
	task automatic step(input logic [2:0] t, input logic rng);
		logic [7:0] d;
		xtal_locked_in <= t[2];
		if (rng) xtal_range_high_in <= t[1];
		else ext_src_lost_in <= t[1];
		repeat (5) @(posedge clk_sys_in);
		chk("status_pin", {7'h00, t[0]}, {7'h00, status_pin_out});
		rd(REG_CTRL, d);
		chk("stat_readback", {7'h00, t[0]}, {7'h00, d[CTRL_STAT_HI]});
	endtask
	task automatic phase(output int p);
		@(posedge post_clk_out);
		p = cyc;
	endtask
	// monitor mode: count feedback rises and model the phase flag
	task automatic mon(input logic [7:0] cv, output int hi, output int rs, output logic ph);
		logic p, pc;
		wr(REG_CTRL, cv);
		repeat (16) @(posedge clk_sys_in);
		hi = 0;
		rs = 0;
		ph = 1'hx;
		p = status_pin_out;
		pc = post_clk_out;
		repeat (64) begin
			@(posedge clk_sys_in);
			hi += status_pin_out;
			if (status_pin_out && !p) begin
				rs++;
				ph = pc; // flag takes the output clock at each feedback rise
			end
			p = status_pin_out;
			pc = post_clk_out;
		end
	endtask
	task automatic results();
		if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		err_total++;
		results();
	end
	initial begin
		logic [7:0] d;
		logic [31:0] r;
		logic [2:0] o;
		int a, b, c, per, k;
		repeat (6) @(posedge clk_sys_in);
		nrst_in <= 1'h1;
		@(posedge clk_sys_in);
		// ****************************************
		// reset values, read-only and unmapped
		// ****************************************
		for (int i = 0; i < 8; i++) begin
			if (i > 4) wr(3'(i), 8'hFF);
			rd(3'(i), d);
			chk("reg_read", rst_v[i], d & (i == 5 ? 8'hF9 : 8'hFF));
		end
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			o = (i == 0) ? 3'h1 : r[10:8];
			wr(REG_XTAL, r[7:0]);
			chk("xtal", {2'h0, r[5:0]}, xtal_obs);
			wr(REG_OSC, {5'h00, o});
			chk("osc_off", {7'h00, o == OSC_SHUTDOWN_CODE}, {7'h00, osc_shutdown_out});
		end
		// ****************************************
		// status pin modes
		// ****************************************
		wr(REG_CTRL, 8'h10);
		foreach (lk_t[i]) step(lk_t[i], 1'h0);
		wr(REG_CTRL, 8'h00);
		chk("pin_off", 8'h02, {6'h00, status_pin_oe_n_out, status_pin_out});
		wr(REG_CTRL, 8'h14);
		foreach (rg_t[i]) step(rg_t[i], 1'h1);
		mon(8'h1C, k, a, o[0]);
		chk("fbk_mon", 8'h01, {7'h00, k > 0 && k < 64});
		chk("fbk_rises", 8'(64 / FDIV_RST), 8'(a));
		mon(8'h1E, k, a, o[0]);
		chk("fbk_post_rises", 8'(64 / (FDIV_RST * PDIV_RST)), 8'(a));
		rd(REG_CTRL, d);
		chk("mon_rb", 8'h1E, d);
		wr(REG_CTRL, 8'h1A);
		repeat (4) @(posedge clk_sys_in);
		rd(REG_STATUS, d);
		chk("phase_pin", {7'h00, o[0]}, {7'h00, status_pin_out});
		chk("phase_sts", {7'h00, o[0]}, {7'h00, d[STS_PHASE]});
		rd(REG_CTRL, d);
		chk("phase_rb", {7'h00, o[0]}, {7'h00, d[CTRL_STAT_HI]});
		// ****************************************
		// gobbler phase slips
		// ****************************************
		for (int t = 0; t < 3; t++) begin
			r = rnd();
			d = {6'h00, r[1:0]} + 8'h02;
			wr(REG_PDIV, d);
			wr(REG_FDIV, {d[6:0], 1'h0});
			wr(REG_CTRL, 8'h02);
			phase(a);
			phase(a);
			phase(b);
			per = b - a;
			chk("post_period", d, 8'(per));
			// keep the slip count below one period so a lost slip shows
			k = 1 + int'(r[3:2]) % (per - 1);
			for (int i = 0; i < k; i++) begin
				wr(REG_CTRL, 8'h03);
				wr(REG_CTRL, 8'h03);
				wr(REG_CTRL, 8'h02);
			end
			repeat (8) @(posedge clk_sys_in);
			phase(c);
			chk("gobble_shift", 8'h00, 8'((c - b - k) % per));
		end
		results();
	end
endmodule // tb
bind pgs_top pgs_assertions pgs_assertions_i (.*);
`default_nettype wire
